// ===== logic/srl_pkg.sv
// Purpose: shared constants of the serial register loader
// Assumes: 24-bit words, control field in the low nibble
// Notes:   field positions are lsb plus width inside a word
package srl_pkg;

  // ************************************************************
  // word layout
  // ************************************************************
  localparam int WORD_W   = 24;
  localparam int CODE_W   = 4;
  localparam int NUM_REGS = 8;
  localparam int IDX_W    = 3;

  // register indices, selected by the control field
  localparam logic [2:0] IDX_RF_FEEDBACK = 3'h0;
  localparam logic [2:0] IDX_RF_REF_DEN  = 3'h1;
  localparam logic [2:0] IDX_IF_FEEDBACK = 3'h2;
  localparam logic [2:0] IDX_IF_REF_PUMP = 3'h3;
  localparam logic [2:0] IDX_FIXED       = 3'h4;
  localparam logic [2:0] IDX_ADV_A       = 3'h5;
  localparam logic [2:0] IDX_ADV_B       = 3'h6;
  localparam logic [2:0] IDX_EXT_FRAC    = 3'h7;
  localparam int         NUM_BASIC       = 4;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int RFN_LSB  = 13;
  localparam int RFN_W    = 11;
  localparam int RFFN_LSB = 1;
  localparam int RFFN_W   = 12;
  localparam int RFPD_BIT = 23;
  localparam int RFP_BIT  = 22;
  localparam int RFR_LSB  = 16;
  localparam int RFR_W    = 6;
  localparam int RFFD_LSB = 4;
  localparam int RFFD_W   = 12;
  localparam int IFPD_BIT = 23;
  localparam int IFN_LSB  = 4;
  localparam int IFN_W    = 19;
  localparam int CPG_LSB  = 16;
  localparam int CPG_W    = 4;
  localparam int IFR_LSB  = 4;
  localparam int IFR_W    = 12;
  localparam int DATA_LSB = 4;
  localparam int DATA_W   = 20;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [23:0] REG_RST   = 24'h000000;
  localparam int          SETTLE_W  = 16;
  localparam int          FLOCK_CYC = 1000;

endpackage

// ===== logic/srl_loader.sv
// Purpose: three-wire serial programming front end, eight latches
// Assumes: host holds the serial clock still while load_strobe rises
// Notes:   shift register on sclk, latches on clk_sys
//
// How it works
// R1: words are 24 bits, shifted before commit
// R2: low four bits choose the target latch
// R3: strobe rising edge copies word into latch
// R4: most significant bit arrives first
// R5: feedback counter write restarts lock circuitry
// R6: restart clears counters, keeps latch contents
// R7: host may skip extended fraction latch
// R8: data in bits 23..4, control 3..0; latch 0 data in 23..1, control bit0
// R9: bit0 low selects latch 0, else bits3..1
// R10: latch 0 holds 11+12 bits in 23..1
// R11: first four latches basic, rest optional
// R12: data sampled on each serial clock rise
// R13: latches 1..3 carry divider, gain, power-down
`timescale 1ns/1ps
`default_nettype none

module srl_loader
  import srl_pkg::*;
#(
  parameter int FLOCK_CYCLES = srl_pkg::FLOCK_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       sclk,
  input  wire logic                       sdata,
  input  wire logic                       load_strobe,
  output logic [srl_pkg::RFN_W-1:0]       rf_feedback_count,
  output logic [srl_pkg::RFFN_W-1:0]      rf_frac_numerator,
  output logic [srl_pkg::RFR_W-1:0]       rf_reference_divide,
  output logic [srl_pkg::RFFD_W-1:0]      rf_frac_denominator,
  output logic                            rf_prescaler_select,
  output logic                            rf_power_down,
  output logic [srl_pkg::IFN_W-1:0]       if_feedback_count,
  output logic                            if_power_down,
  output logic [srl_pkg::IFR_W-1:0]       if_reference_divide,
  output logic [srl_pkg::CPG_W-1:0]       rf_pump_gain,
  output logic [srl_pkg::DATA_W-1:0]      fixed_pattern_data,
  output logic [srl_pkg::DATA_W-1:0]      advanced_a_data,
  output logic [srl_pkg::DATA_W-1:0]      advanced_b_data,
  output logic [srl_pkg::DATA_W-1:0]      extended_fraction_data,
  output logic                            lock_init,
  output logic                            fastlock_active,
  output logic                            basic_ready
);

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic [WORD_W-1:0] shift;
  } srl_ser_t;

  typedef struct packed {
    logic                             ls1;
    logic                             ls2;
    logic                             ls3;
    logic [NUM_REGS-1:0][WORD_W-1:0]  regs;
    logic [NUM_BASIC-1:0]             seen;
    logic                             basic_ready;
    logic                             lock_init;
    logic                             fastlock;
    logic [SETTLE_W-1:0]              settle;
  } srl_sys_t;

  // ************************************************************
  // decode
  // ************************************************************
  // returns {valid, index}; 0001 is not a mapped address
  function automatic logic [IDX_W:0] srl_decode(
    input logic [CODE_W-1:0] code
  );
    if (!code[0]) begin
      return {1'b1, IDX_RF_FEEDBACK};                    // [R9]
    end else if (code[3:1] != 3'h0) begin
      return {1'b1, code[3:1]};                          // [R9]
    end else begin
      return {1'b0, 3'h0};
    end
  endfunction

  // one-hot latch select, shared by the write path and the checks
  function automatic logic [NUM_REGS-1:0] srl_select(
    input logic [IDX_W:0] d,
    input logic           go
  );
    logic [NUM_REGS-1:0] s;
    s = '0;
    if (go && d[IDX_W]) begin
      s[d[IDX_W-1:0]] = 1'b1;
    end
    return s;
  endfunction

  localparam logic [SETTLE_W-1:0] FLOCK_LIM =
    SETTLE_W'(FLOCK_CYCLES);

  // ************************************************************
  // serial domain
  // ************************************************************
  // no reset here: the host clock may be still, and the word is
  // only trusted once a full frame has been shifted in
  srl_ser_t ser_ff;
  srl_ser_t nxt_ser;

  always_comb begin
    nxt_ser = ser_ff;
    // previous bits move toward the msb, new bit enters at 0
    nxt_ser.shift = {ser_ff.shift[WORD_W-2:0], sdata}; // [R1] [R4] [R12]
  end

  always_ff @(posedge sclk) begin
    ser_ff <= nxt_ser;
  end

  // ************************************************************
  // system domain
  // ************************************************************
  srl_sys_t             st_ff;
  srl_sys_t             nxt_st;
  logic                 commit;
  logic [IDX_W:0]       dec;
  logic [NUM_REGS-1:0]  sel;

  // word is quasi-static when the synced strobe rises, since the
  // serial clock is idle around the strobe
  assign commit = st_ff.ls2 & ~st_ff.ls3;                // [R3]
  assign dec    = srl_decode(ser_ff.shift[CODE_W-1:0]);  // [R2] [R8]
  assign sel    = srl_select(dec, commit);               // [R3]

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.ls1       = load_strobe;
    nxt_st.ls2       = st_ff.ls1;
    nxt_st.ls3       = st_ff.ls2;
    nxt_st.lock_init = 1'b0;
    // at most one latch takes the word; none for code 0001
    for (int i = 0; i < NUM_REGS; i++) begin
      if (sel[i]) begin
        nxt_st.regs[i] = ser_ff.shift;                   // [R3]
      end
    end
    // track which basic latches hold a programmed value
    for (int i = 0; i < NUM_BASIC; i++) begin
      if (sel[i]) begin
        nxt_st.seen[i] = 1'b1;                           // [R11]
      end
    end
    nxt_st.basic_ready = &st_ff.seen;                    // [R11]
    // counters only; the latch contents are left alone
    if (sel[IDX_RF_FEEDBACK]) begin
      nxt_st.lock_init = 1'b1;                           // [R5]
      nxt_st.settle    = '0;                             // [R6]
      nxt_st.fastlock  = 1'b1;                           // [R6]
    end else if (st_ff.settle < FLOCK_LIM) begin
      nxt_st.settle    = st_ff.settle + SETTLE_W'(1);
      nxt_st.fastlock  = (st_ff.settle + SETTLE_W'(1)) < FLOCK_LIM;
    end else begin
      nxt_st.fastlock  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_ff.ls1         <= 1'b0;
      st_ff.ls2         <= 1'b0;
      st_ff.ls3         <= 1'b0;
      // unwritten extended fraction latch simply stays zero  [R7]
      st_ff.regs        <= {NUM_REGS{REG_RST}};
      st_ff.seen        <= '0;
      st_ff.basic_ready <= 1'b0;
      st_ff.lock_init   <= 1'b0;
      st_ff.fastlock    <= 1'b0;
      // parked at its end so no fastlock burst follows reset
      st_ff.settle      <= FLOCK_LIM;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // field outputs, straight from latch bits
  // ************************************************************
  assign rf_feedback_count   = st_ff.regs[0][RFN_LSB +: RFN_W];   // [R10]
  assign rf_frac_numerator   = st_ff.regs[0][RFFN_LSB +: RFFN_W]; // [R10]
  assign rf_power_down       = st_ff.regs[1][RFPD_BIT];           // [R13]
  assign rf_prescaler_select = st_ff.regs[1][RFP_BIT];            // [R13]
  assign rf_reference_divide = st_ff.regs[1][RFR_LSB +: RFR_W];   // [R13]
  assign rf_frac_denominator = st_ff.regs[1][RFFD_LSB +: RFFD_W]; // [R13]
  assign if_power_down       = st_ff.regs[2][IFPD_BIT];           // [R13]
  assign if_feedback_count   = st_ff.regs[2][IFN_LSB +: IFN_W];   // [R13]
  assign rf_pump_gain        = st_ff.regs[3][CPG_LSB +: CPG_W];   // [R13]
  assign if_reference_divide = st_ff.regs[3][IFR_LSB +: IFR_W];   // [R13]
  assign fixed_pattern_data     = st_ff.regs[4][DATA_LSB +: DATA_W];
  assign advanced_a_data        = st_ff.regs[5][DATA_LSB +: DATA_W];
  assign advanced_b_data        = st_ff.regs[6][DATA_LSB +: DATA_W];
  assign extended_fraction_data = st_ff.regs[7][DATA_LSB +: DATA_W];
  assign lock_init              = st_ff.lock_init;
  assign fastlock_active        = st_ff.fastlock;
  assign basic_ready            = st_ff.basic_ready;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_commit_any;
    commit && dec[IDX_W];
  endsequence

  sequence s_commit_r0;
    commit && dec[IDX_W] && dec[IDX_W-1:0] == IDX_RF_FEEDBACK;
  endsequence

  commit_write_a: assert property (                       // [R3]
    @(posedge clk_sys) disable iff (!rstn)
    s_commit_any |=> st_ff.regs[$past(dec[IDX_W-1:0])] ==
                     $past(ser_ff.shift))
    else $error("selected latch did not take the word");

  for (genvar g = 0; g < NUM_REGS; g++) begin : g_keep
    only_target_a: assert property (                      // [R3]
      @(posedge clk_sys) disable iff (!rstn)
      !(commit && dec[IDX_W] && dec[IDX_W-1:0] == IDX_W'(g))
      |=> $stable(st_ff.regs[g]))
      else $error("unselected latch changed");
  end

  reg0_select_a: assert property (                        // [R9] [R2]
    @(posedge clk_sys) disable iff (!rstn)
    commit && !ser_ff.shift[0] |=> st_ff.regs[0] ==
                                  $past(ser_ff.shift))
    else $error("bit0 low did not select latch 0");

  init_pulse_a: assert property (                         // [R5]
    @(posedge clk_sys) disable iff (!rstn)
    s_commit_r0 |=> lock_init ##1 !lock_init)
    else $error("lock restart pulse missing or long");

  init_cause_a: assert property (                         // [R5]
    @(posedge clk_sys) disable iff (!rstn)
    $rose(lock_init) |-> $past(commit) && $past(dec[IDX_W]) &&
                         $past(dec[IDX_W-1:0]) == IDX_RF_FEEDBACK)
    else $error("lock restart without feedback write");

  init_keeps_a: assert property (                         // [R6]
    @(posedge clk_sys) disable iff (!rstn)
    lock_init |=> $stable(st_ff.regs))
    else $error("restart disturbed latch contents");

  settle_clear_a: assert property (                       // [R6]
    @(posedge clk_sys) disable iff (!rstn)
    lock_init |-> st_ff.settle == '0 && fastlock_active
                  ##1 st_ff.settle == SETTLE_W'(1))
    else $error("lock counters not restarted");

  field_map_a: assert property (                          // [R10] [R8]
    @(posedge clk_sys) disable iff (!rstn)
    s_commit_r0 |=>
      rf_feedback_count == $past(ser_ff.shift[23:13]) &&
      rf_frac_numerator == $past(ser_ff.shift[12:1]))
    else $error("latch 0 fields misplaced");

  if_fields_a: assert property (                          // [R13]
    @(posedge clk_sys) disable iff (!rstn)
    commit && ser_ff.shift[3:0] == 4'h5 |=>
      if_feedback_count == $past(ser_ff.shift[22:4]) &&
      if_power_down == $past(ser_ff.shift[23]))
    else $error("latch 2 fields misplaced");

  unmapped_a: assert property (                           // [R9]
    @(posedge clk_sys) disable iff (!rstn)
    commit && ser_ff.shift[3:0] == 4'h1 |=> $stable(st_ff.regs))
    else $error("unmapped address wrote a latch");

  sequence s_fl_last;
    fastlock_active && st_ff.settle == FLOCK_LIM - SETTLE_W'(1);
  endsequence

  sequence s_strobe_seen;
    st_ff.ls2 && !st_ff.ls3;
  endsequence

  one_latch_a: assert property (                          // [R3]
    @(posedge clk_sys) disable iff (!rstn)
    $onehot0(sel))
    else $error("more than one latch selected");

  commit_once_a: assert property (                        // [R3]
    @(posedge clk_sys) disable iff (!rstn)
    s_strobe_seen |=> !commit)
    else $error("one strobe committed twice");

  for (genvar g = 1; g < NUM_REGS; g++) begin : g_map
    decode_map_a: assert property (                       // [R9] [R2]
      @(posedge clk_sys) disable iff (!rstn)
      commit && ser_ff.shift[CODE_W-1:0] == CODE_W'(2 * g + 1) |=>
        st_ff.regs[g] == $past(ser_ff.shift))
      else $error("control field reached the wrong latch");
  end

  odd_no_init_a: assert property (                        // [R5]
    @(posedge clk_sys) disable iff (!rstn)
    commit && ser_ff.shift[0] |=> !lock_init)
    else $error("lock restart from another latch");

  fastlock_end_a: assert property (                       // [R6]
    @(posedge clk_sys) disable iff (!rstn)
    s_fl_last ##0 !sel[IDX_RF_FEEDBACK] |=> !fastlock_active)
    else $error("fastlock ran past its span");

  fastlock_span_a: assert property (                      // [R6]
    @(posedge clk_sys) disable iff (!rstn)
    fastlock_active |-> st_ff.settle < FLOCK_LIM)
    else $error("fastlock high outside its span");

  settle_step_a: assert property (                        // [R6]
    @(posedge clk_sys) disable iff (!rstn)
    fastlock_active && !sel[IDX_RF_FEEDBACK] |=>
      st_ff.settle == $past(st_ff.settle) + SETTLE_W'(1))
    else $error("lock counter did not advance");

  reset_quiet_a: assert property (                        // [R5]
    @(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> !fastlock_active && !lock_init
                    ##1 !fastlock_active && !lock_init)
    else $error("lock circuitry active after reset");

  for (genvar g = 0; g < NUM_BASIC; g++) begin : g_seen
    seen_set_a: assert property (                         // [R11]
      @(posedge clk_sys) disable iff (!rstn)
      sel[g] |=> st_ff.seen[g])
      else $error("basic latch write not recorded");
  end

  ready_hold_a: assert property (                         // [R11]
    @(posedge clk_sys) disable iff (!rstn)
    basic_ready |=> basic_ready)
    else $error("basic ready dropped without reset");

  ready_cause_a: assert property (                        // [R11]
    @(posedge clk_sys) disable iff (!rstn)
    basic_ready |-> &st_ff.seen)
    else $error("basic ready before all basic latches");

endmodule

`default_nettype wire

// ===== dv/srl_host.sv
// Purpose: host model driving the three-wire programming link
// Assumes: serial clock idles low and stands still between words
// Notes:   data flips after the hold time so stale bits never pass
`timescale 1ns/1ps
`default_nettype none

module srl_host (
  output logic sclk,
  output logic sdata,
  output logic load_strobe
);
  initial begin
    sclk        = 1'b0;
    sdata       = 1'b0;
    load_strobe = 1'b0;
  end

  // ************************************************************
  // one word, msb first; extra delays the first bit so the
  // 32 ns serial clock drifts against the system clock
  // ************************************************************
  task automatic send(input logic [23:0] w, input int extra);
    #(extra);
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 load_strobe = 1'b1;
    // word held well past the 24 ns capture window
    #56 load_strobe = 1'b0;
    #32 sdata = ~sdata;
  endtask
endmodule

`default_nettype wire

// ===== dv/testbench.sv
// Purpose: self-checking bench of the serial register loader
// Assumes: fastlock span shortened to 8 cycles
// Notes:   all latch outputs are compared as one packed vector
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import srl_pkg::*;
  localparam int FL = 8;
  logic         clk_sys = 1'b0;
  logic         rstn = 1'b0;
  wire logic    sclk;
  wire logic    sdata;
  wire logic    load_strobe;
  wire logic    lock_init;
  wire logic    fastlock_active;
  wire logic    basic_ready;
  wire logic [158:0] seen;
  logic [23:0]  sh [8];
  logic [3:0]   wr_mask = '0;
  int mismatches = 0;
  int n_compared = 0;
  int n0 = 0;
  int lock_cnt = 0;
  int fl_cyc = 0;

  always #4 clk_sys = ~clk_sys;

  srl_host srl_host_inst (.sclk(sclk), .sdata(sdata),
    .load_strobe(load_strobe));

  srl_loader #(.FLOCK_CYCLES(FL)) srl_loader_inst (
    .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .sdata(sdata),
    .load_strobe(load_strobe),
    .rf_feedback_count(seen[158:148]), .rf_frac_numerator(seen[147:136]),
    .rf_reference_divide(seen[135:130]),
    .rf_frac_denominator(seen[129:118]),
    .rf_prescaler_select(seen[117]), .rf_power_down(seen[116]),
    .if_feedback_count(seen[115:97]), .if_power_down(seen[96]),
    .if_reference_divide(seen[95:84]), .rf_pump_gain(seen[83:80]),
    .fixed_pattern_data(seen[79:60]), .advanced_a_data(seen[59:40]),
    .advanced_b_data(seen[39:20]), .extended_fraction_data(seen[19:0]),
    .lock_init(lock_init), .fastlock_active(fastlock_active),
    .basic_ready(basic_ready));

  always @(posedge clk_sys) begin
    if (lock_init === 1'b1) lock_cnt++;
    if (fastlock_active === 1'b1) fl_cyc++;
  end

  // ************************************************************
  // expectations and checks
  // ************************************************************
  function automatic logic [158:0] expect_out();
    return {sh[0][23:13], sh[0][12:1], sh[1][21:16], sh[1][15:4],
      sh[1][22], sh[1][23], sh[2][22:4], sh[2][23], sh[3][15:4],
      sh[3][19:16], sh[4][23:4], sh[5][23:4], sh[6][23:4], sh[7][23:4]};
  endfunction

  function automatic int target(input logic [3:0] c);
    if (!c[0]) return 0;
    return (c[3:1] == 3'h0) ? -1 : int'(c[3:1]);
  endfunction

  task automatic check(input logic [158:0] s, e, input string m);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic put(input logic [19:0] d, input logic [3:0] c);
    int t;
    t = target(c);
    srl_host_inst.send({d, c}, $urandom_range(0, 20));
    if (t >= 0) sh[t] = {d, c};
    if (t >= 0 && t < 4) wr_mask[t] = 1'b1;
    if (t == 0) n0++;
    repeat (16) @(posedge clk_sys);
    check(seen, expect_out(), "latch contents");
    check(basic_ready, &wr_mask, "basic ready");
    check(lock_cnt, n0, "lock restart count");
    check(fl_cyc, n0 * FL, "fastlock span");
  endtask

  task automatic do_reset();
    @(posedge clk_sys) #1 rstn = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rstn = 1'b1;
    foreach (sh[i]) sh[i] = '0;
    wr_mask = '0;
    repeat (4) @(posedge clk_sys);
    check(seen, '0, "reset values");
    check(basic_ready, 1'b0, "ready after reset");
    check(fastlock_active, 1'b0, "fastlock after reset");
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    void'($urandom(32'ha361));
    do_reset();
    // optional latches first so ready must wait for the basic four
    for (int i = 7; i >= 0; i--) put(20'($urandom), {i[2:0], i != 0});
    put(20'($urandom), 4'h1);
    for (int i = 0; i < 8; i++) put(20'($urandom), {i[2:0], 1'b0});
    repeat (30) put(20'($urandom), 4'($urandom));
    do_reset();
    // basic set only, extended fraction latch skipped
    for (int i = 3; i >= 0; i--) put(20'($urandom), {i[2:0], i != 0});
    end_sim();
  end

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule

`default_nettype wire
